// ---- pibr_pkg.sv ----
package pibr_pkg;
  // configuration offsets
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_DMA_TIMING = 8'h45;
  localparam logic [7:0] OFS_MISC_ONE = 8'h46;
  localparam logic [7:0] OFS_MISC_TWO = 8'h47;
  localparam logic [7:0] OFS_MISC_THREE = 8'h48;
  localparam logic [7:0] OFS_DISK_IRQ = 8'h4A;
  localparam logic [7:0] OFS_HOLE_BOTTOM = 8'h4C;
  localparam logic [7:0] OFS_HOLE_TOP = 8'h4D;
  localparam logic [7:0] OFS_FWD_LOW = 8'h4E;
  localparam logic [7:0] OFS_FWD_HIGH = 8'h4F;
  localparam logic [7:0] OFS_DRQ_ROUTING = 8'h50;
  localparam logic [7:0] OFS_IRQ_TRIGGER = 8'h54;
  // reset values
  localparam logic [7:0] RST_MISC_THREE = 8'h01;
  localparam logic [7:0] RST_DISK_IRQ = 8'h04;
  localparam logic [7:0] RST_FWD_LOW = 8'h00;
  localparam logic [7:0] RST_FWD_HIGH = 8'h03;
  localparam logic [7:0] VAL_DRQ_ROUTING = 8'h04;
  // writable bits of each register
  localparam logic [7:0] WM_MISC_ONE = 8'h13;
  localparam logic [7:0] WM_MISC_TWO = 8'hF7;
  localparam logic [7:0] WM_MISC_THREE = 8'h0F;
  localparam logic [7:0] WM_DISK_IRQ = 8'hCF;
  localparam logic [7:0] WM_IRQ_TRIGGER = 8'h0F;
  // field positions
  localparam int B_LINE_BUF = 7;
  localparam int B_CMD_TEST = 4;
  localparam int B_BURST_NB = 1;
  localparam int B_POST_WR = 0;
  localparam int B_RESTART_SRC = 7;
  localparam int B_DELAYED = 6;
  localparam int B_EISA = 5;
  localparam int B_SHADOW = 4;
  localparam int B_WR_TIMER = 2;
  localparam int B_RD_TIMER = 1;
  localparam int B_BUS_RESET = 0;
  localparam int B_EXTRA_CLK = 3;
  localparam int B_USB_DIS = 2;
  localparam int B_IDE_DIS = 1;
  localparam int B_HALF_MB = 0;
  localparam int B_WAIT_GNT = 7;
  localparam int B_LOW_IO = 6;
  localparam int B_CMD_SCE = 3;
  // i/o port numbers that the block decodes
  localparam logic [15:0] PORT_EISA_EL = 16'h04D0;
  localparam logic [15:0] PORT_EXTRA_CLK = 16'h0074;
endpackage

// ---- pibr_config_regs.sv ----
`timescale 1ns/10ps
// Functional notes
// - each channel bit selects fast type F dma timing; all default normal.
// - top bit of dma timing register enables line buffer; off after reset.
// - test bit makes command bits 0-1 writable, bit 3 read-only; else reversed.
// - burst-interrupt bit set forbids breaking pci burst reads; default allowed.
// - memory writes are posted only while posted-write bit is set.
// - restart source bit picks warm-init signal, else dedicated restart pin.
// - delayed transactions only while delayed-transaction bit set; cleared at reset.
// - eisa port bit enables decode of ports 4D0h-4D1h; default ignored.
// - interrupt controller shadow registers enabled only while shadow bit set.
// - separate bits enable write and read delayed time-out timers; both off.
// - writing one to software reset bit asserts the pci bus reset output.
// - extra clock port bit is active low; zero enables ports 74h/75h.
// - usb or ide disable bit turns off that unit; both enabled by default.
// - half-mb bit set adds 512 KB to top of memory; default set.
// - wait-grant bit holds isa grant until pci bus grant; software sets it.
// - low io select routes ports 00h-FFh over XD bus, else SD bus.
// - disk irq fields map 00/01/10/11 to irq 14/15/10/11; defaults 00, 01.
// - hole bottom and top hold address bits 23-16; hole not forwarded.
// - hole exclusion inactive when top is less than or equal to bottom.
// - top-of-memory field is 1 MB per step; accesses above not forwarded.
// - twelve range bits enable low-memory forwarding; two below 640 KB default on.
// - each pci interrupt select bit inverts its line and marks it edge.
module pibr_config_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic dma_chan0_fast_timing,
  output logic dma_chan1_fast_timing,
  output logic dma_chan2_fast_timing,
  output logic dma_chan3_fast_timing,
  output logic dma_chan5_fast_timing,
  output logic dma_chan6_fast_timing,
  output logic dma_chan7_fast_timing,
  output logic line_buffer_enable,
  output logic io_space_enable,
  output logic mem_space_enable,
  output logic special_cycle_enable,
  output logic burst_read_no_break,
  output logic posted_write_enable,
  output logic delayed_txn_enable,
  output logic irq_ctrl_shadow_enable,
  output logic write_delay_timer_enable,
  output logic read_delay_timer_enable,
  output logic bus_reset_out,
  output logic serial_bus_unit_disable,
  output logic disk_unit_disable,
  output logic low_io_bus_select,
  input wire logic restart_req,
  output logic cpu_hard_restart_pin,
  output logic cpu_warm_init,
  input wire logic [15:0] io_addr,
  input wire logic io_access,
  output logic eisa_port_hit,
  output logic extra_clock_port_hit,
  input wire logic isa_master_req,
  input wire logic bridge_bus_grant,
  output logic isa_master_grant,
  input wire logic [23:0] isa_addr,
  output logic isa_fwd_to_pci,
  output logic [3:0] disk_primary_irq_sel,
  output logic [3:0] disk_secondary_irq_sel,
  input wire logic pci_int_line_a,
  input wire logic pci_int_line_b,
  input wire logic pci_int_line_c,
  input wire logic pci_int_line_d,
  output logic [3:0] pci_int_out,
  output logic [3:0] pci_int_edge
);

  typedef struct packed {
    logic [7:0] dma_timing;
    logic [7:0] misc_one;
    logic [7:0] misc_two;
    logic [7:0] misc_three;
    logic [7:0] disk_irq;
    logic [7:0] hole_bottom;
    logic [7:0] hole_top;
    logic [7:0] fwd_low;
    logic [7:0] fwd_high;
    logic [3:0] irq_trigger;
    logic cmd_io;
    logic cmd_mem;
    logic cmd_sce;
    logic [7:0] rdata;
    logic [3:0] int_s1;
    logic [3:0] int_s2;
    logic [3:0] int_s3;
    logic [3:0] int_val;
    logic gnt_s1;
    logic gnt_s2;
    logic gnt_s3;
    logic gnt_val;
    logic grant;
    logic fwd;
    logic eisa_hit;
    logic clk_hit;
    logic [3:0] pri_irq;
    logic [3:0] sec_irq;
    logic [3:0] int_out;
    logic cpu_pin;
    logic cpu_init;
  } pibr_state_t;

  pibr_state_t st;
  pibr_state_t next_st;

  function automatic logic [3:0] pibr_irq_num(input logic [1:0] sel);
    case (sel)
      2'h0: pibr_irq_num = 4'hE;
      2'h1: pibr_irq_num = 4'hF;
      2'h2: pibr_irq_num = 4'hA;
      default: pibr_irq_num = 4'hB;
    endcase
  endfunction

  // low-memory range enable picked by address; the F segment has no bit
  function automatic logic pibr_range_on(input logic [19:0] a, input logic [11:0] en);
    if (!a[19]) begin
      pibr_range_on = en[8];
    end else if (a[19:17] == 3'h4) begin
      pibr_range_on = en[9];
    end else if (a[19:17] == 3'h5) begin
      pibr_range_on = en[10];
    end else if (a[19:17] == 3'h6) begin
      pibr_range_on = en[a[16:14]];
    end else if (a[19:16] == 4'hE) begin
      pibr_range_on = en[11];
    end else begin
      pibr_range_on = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic wr_hit;
  logic [15:0] fwd_ctl;
  logic [5:0] top_half_mb;
  logic below_top;
  logic in_hole;
  logic [3:0] pin_in;

  always_comb begin
    wr_hit = cfg_wr;
    fwd_ctl = {st.fwd_high, st.fwd_low};
    pin_in = {pci_int_line_a, pci_int_line_b, pci_int_line_c, pci_int_line_d};
    // top in 512 KB units: (field + 1) MB, plus half a MB when selected
    top_half_mb = {1'b0, fwd_ctl[15:12], 1'b0} + 6'h02
      + {5'h00, st.misc_three[pibr_pkg::B_HALF_MB]};
    below_top = {1'b0, isa_addr[23:19]} < top_half_mb;
    in_hole = (st.hole_top > st.hole_bottom)
      && (isa_addr[23:16] >= st.hole_bottom)
      && (isa_addr[23:16] < st.hole_top);
    next_st = st;
    next_st.rdata = 8'h00;
    if (wr_hit) begin
      case (cfg_addr)
        pibr_pkg::OFS_COMMAND: begin
          if (st.misc_one[pibr_pkg::B_CMD_TEST]) begin
            next_st.cmd_io = cfg_wdata[0];
            next_st.cmd_mem = cfg_wdata[1];
          end else begin
            next_st.cmd_sce = cfg_wdata[pibr_pkg::B_CMD_SCE];
          end
        end
        pibr_pkg::OFS_DMA_TIMING: next_st.dma_timing = cfg_wdata;
        pibr_pkg::OFS_MISC_ONE: next_st.misc_one = cfg_wdata & pibr_pkg::WM_MISC_ONE;
        pibr_pkg::OFS_MISC_TWO: next_st.misc_two = cfg_wdata & pibr_pkg::WM_MISC_TWO;
        pibr_pkg::OFS_MISC_THREE: next_st.misc_three = cfg_wdata & pibr_pkg::WM_MISC_THREE;
        pibr_pkg::OFS_DISK_IRQ: next_st.disk_irq = cfg_wdata & pibr_pkg::WM_DISK_IRQ;
        pibr_pkg::OFS_HOLE_BOTTOM: next_st.hole_bottom = cfg_wdata;
        pibr_pkg::OFS_HOLE_TOP: next_st.hole_top = cfg_wdata;
        pibr_pkg::OFS_FWD_LOW: next_st.fwd_low = cfg_wdata;
        pibr_pkg::OFS_FWD_HIGH: next_st.fwd_high = cfg_wdata;
        pibr_pkg::OFS_IRQ_TRIGGER: begin
          next_st.irq_trigger = cfg_wdata[3:0] & pibr_pkg::WM_IRQ_TRIGGER[3:0];
        end
        default: begin
        end
      endcase
    end
    if (cfg_rd) begin
      case (cfg_addr)
        pibr_pkg::OFS_COMMAND: begin
          // whichever bits are read-only in the current mode read back as one
          if (st.misc_one[pibr_pkg::B_CMD_TEST]) begin
            next_st.rdata = {4'h0, 1'b1, 1'b0, st.cmd_mem, st.cmd_io};
          end else begin
            next_st.rdata = {4'h0, st.cmd_sce, 1'b0, 2'h3};
          end
        end
        pibr_pkg::OFS_DMA_TIMING: next_st.rdata = st.dma_timing;
        pibr_pkg::OFS_MISC_ONE: next_st.rdata = st.misc_one;
        pibr_pkg::OFS_MISC_TWO: next_st.rdata = st.misc_two;
        pibr_pkg::OFS_MISC_THREE: next_st.rdata = st.misc_three;
        pibr_pkg::OFS_DISK_IRQ: next_st.rdata = st.disk_irq;
        pibr_pkg::OFS_HOLE_BOTTOM: next_st.rdata = st.hole_bottom;
        pibr_pkg::OFS_HOLE_TOP: next_st.rdata = st.hole_top;
        pibr_pkg::OFS_FWD_LOW: next_st.rdata = st.fwd_low;
        pibr_pkg::OFS_FWD_HIGH: next_st.rdata = st.fwd_high;
        pibr_pkg::OFS_DRQ_ROUTING: next_st.rdata = pibr_pkg::VAL_DRQ_ROUTING;
        pibr_pkg::OFS_IRQ_TRIGGER: next_st.rdata = {4'h0, st.irq_trigger};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // pin inputs: three flops, a change counts once stages two and three agree
    next_st.int_s1 = pin_in;
    next_st.int_s2 = st.int_s1;
    next_st.int_s3 = st.int_s2;
    for (int i = 0; i < 4; i++) begin
      if (st.int_s2[i] == st.int_s3[i]) begin
        next_st.int_val[i] = st.int_s3[i];
      end
      next_st.int_out[i] = st.int_val[i] ^ st.irq_trigger[i];
    end
    next_st.gnt_s1 = bridge_bus_grant;
    next_st.gnt_s2 = st.gnt_s1;
    next_st.gnt_s3 = st.gnt_s2;
    if (st.gnt_s2 == st.gnt_s3) begin
      next_st.gnt_val = st.gnt_s3;
    end
    next_st.grant = isa_master_req
      && (!st.disk_irq[pibr_pkg::B_WAIT_GNT] || st.gnt_val);
    next_st.fwd = below_top && !in_hole
      && ((isa_addr[23:20] != 4'h0) || pibr_range_on(isa_addr[19:0], fwd_ctl[11:0]));
    next_st.eisa_hit = io_access && st.misc_two[pibr_pkg::B_EISA]
      && (io_addr[15:1] == pibr_pkg::PORT_EISA_EL[15:1]);
    next_st.clk_hit = io_access && !st.misc_three[pibr_pkg::B_EXTRA_CLK]
      && (io_addr[15:1] == pibr_pkg::PORT_EXTRA_CLK[15:1]);
    next_st.pri_irq = pibr_irq_num(st.disk_irq[1:0]);
    next_st.sec_irq = pibr_irq_num(st.disk_irq[3:2]);
    next_st.cpu_pin = restart_req && !st.misc_two[pibr_pkg::B_RESTART_SRC];
    next_st.cpu_init = restart_req && st.misc_two[pibr_pkg::B_RESTART_SRC];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.misc_three <= pibr_pkg::RST_MISC_THREE;
      st.disk_irq <= pibr_pkg::RST_DISK_IRQ;
      st.fwd_low <= pibr_pkg::RST_FWD_LOW;
      st.fwd_high <= pibr_pkg::RST_FWD_HIGH;
      st.cmd_io <= 1'b1;
      st.cmd_mem <= 1'b1;
      st.cmd_sce <= 1'b1;
      st.pri_irq <= 4'hE;
      st.sec_irq <= 4'hF;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // every output is a field of the registered state
  assign cfg_rdata = st.rdata;
  assign dma_chan0_fast_timing = st.dma_timing[0];
  assign dma_chan1_fast_timing = st.dma_timing[1];
  assign dma_chan2_fast_timing = st.dma_timing[2];
  assign dma_chan3_fast_timing = st.dma_timing[3];
  assign dma_chan5_fast_timing = st.dma_timing[4];
  assign dma_chan6_fast_timing = st.dma_timing[5];
  assign dma_chan7_fast_timing = st.dma_timing[6];
  assign line_buffer_enable = st.dma_timing[pibr_pkg::B_LINE_BUF];
  assign io_space_enable = st.cmd_io;
  assign mem_space_enable = st.cmd_mem;
  assign special_cycle_enable = st.cmd_sce;
  assign burst_read_no_break = st.misc_one[pibr_pkg::B_BURST_NB];
  assign posted_write_enable = st.misc_one[pibr_pkg::B_POST_WR];
  assign delayed_txn_enable = st.misc_two[pibr_pkg::B_DELAYED];
  assign irq_ctrl_shadow_enable = st.misc_two[pibr_pkg::B_SHADOW];
  assign write_delay_timer_enable = st.misc_two[pibr_pkg::B_WR_TIMER];
  assign read_delay_timer_enable = st.misc_two[pibr_pkg::B_RD_TIMER];
  // reset stays asserted until software writes the bit back to zero
  assign bus_reset_out = st.misc_two[pibr_pkg::B_BUS_RESET];
  assign serial_bus_unit_disable = st.misc_three[pibr_pkg::B_USB_DIS];
  assign disk_unit_disable = st.misc_three[pibr_pkg::B_IDE_DIS];
  assign low_io_bus_select = st.disk_irq[pibr_pkg::B_LOW_IO];
  assign cpu_hard_restart_pin = st.cpu_pin;
  assign cpu_warm_init = st.cpu_init;
  assign eisa_port_hit = st.eisa_hit;
  assign extra_clock_port_hit = st.clk_hit;
  assign isa_master_grant = st.grant;
  assign isa_fwd_to_pci = st.fwd;
  assign disk_primary_irq_sel = st.pri_irq;
  assign disk_secondary_irq_sel = st.sec_irq;
  assign pci_int_out = st.int_out;
  assign pci_int_edge = st.irq_trigger;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence cmd_write_normal_s;
    cfg_wr && cfg_addr == pibr_pkg::OFS_COMMAND && !st.misc_one[pibr_pkg::B_CMD_TEST];
  endsequence

  sequence drq_read_s;
    cfg_rd && cfg_addr == pibr_pkg::OFS_DRQ_ROUTING;
  endsequence

  sequence disk_irq_wait_s;
    st.disk_irq[pibr_pkg::B_WAIT_GNT] && !st.gnt_val;
  endsequence

  cmd_ro_bits_a: assert property (
    cmd_write_normal_s |=> $stable(st.cmd_io) && $stable(st.cmd_mem))
    else $error("command space bits changed in normal mode");

  drq_fixed_a: assert property (drq_read_s |=> cfg_rdata == pibr_pkg::VAL_DRQ_ROUTING)
    else $error("dma request routing did not read fixed value");

  bus_reset_a: assert property (
    cfg_wr && cfg_addr == pibr_pkg::OFS_MISC_TWO && cfg_wdata[0] |=> bus_reset_out)
    else $error("software reset write did not assert bus reset");

  grant_wait_a: assert property (
    disk_irq_wait_s |=> !isa_master_grant)
    else $error("isa grant given before pci bus grant");

  hole_block_a: assert property (
    in_hole |=> !isa_fwd_to_pci)
    else $error("access inside memory hole forwarded");

  eisa_ignore_a: assert property (
    !st.misc_two[pibr_pkg::B_EISA] |=> !eisa_port_hit)
    else $error("eisa port decoded while disabled");

  irq_map_a: assert property (
    ##1 disk_primary_irq_sel == pibr_irq_num($past(st.disk_irq[1:0])))
    else $error("primary disk irq mapping wrong");

  restart_sel_a: assert property (
    restart_req && !st.misc_two[pibr_pkg::B_RESTART_SRC]
      |=> cpu_hard_restart_pin && !cpu_warm_init)
    else $error("restart went to wrong output");

  int_settle_a: assert property (
    // pins and select both quiet long enough to flush the three-stage synchroniser
    ($stable(pin_in) && $stable(st.irq_trigger))[*5]
      |=> pci_int_out == ($past(pin_in) ^ $past(st.irq_trigger)))
    else $error("pci interrupt line not passed with select");

  top_limit_a: assert property (
    !below_top |=> !isa_fwd_to_pci)
    else $error("access above top of memory forwarded");

endmodule

// ---- pibr_arbiter_model.sv ----
`timescale 1ns/10ps
module pibr_arbiter_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic [4:0] grant_delay,
  output logic bridge_bus_grant
);
  logic [4:0] wait_cnt;
  // grant comes after a programmable stall, so slow and prompt arbiters can both be shown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 5'h00;
      bridge_bus_grant <= 1'b0;
    end else if (!bus_req) begin
      wait_cnt <= 5'h00;
      bridge_bus_grant <= 1'b0;
    end else if (wait_cnt >= grant_delay) begin
      bridge_bus_grant <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 5'h01;
    end
  end
endmodule

// ---- pci_isa_bridge_config_regs_tb.sv ----
`timescale 1ns/10ps
module pci_isa_bridge_config_regs_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, restart_req = 1'b0, io_access = 1'b0;
  logic isa_master_req = 1'b0, bridge_bus_grant;
  logic pci_int_line_a = 1'b0, pci_int_line_b = 1'b0, pci_int_line_c = 1'b0;
  logic pci_int_line_d = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic [15:0] io_addr = 16'h0000;
  logic [23:0] isa_addr = 24'h000000;
  logic [4:0] grant_delay = 5'h04;
  logic dma_chan0_fast_timing, dma_chan1_fast_timing, dma_chan2_fast_timing;
  logic dma_chan3_fast_timing, dma_chan5_fast_timing, dma_chan6_fast_timing;
  logic dma_chan7_fast_timing, line_buffer_enable, io_space_enable, mem_space_enable;
  logic special_cycle_enable, burst_read_no_break, posted_write_enable, delayed_txn_enable;
  logic irq_ctrl_shadow_enable, write_delay_timer_enable, read_delay_timer_enable;
  logic bus_reset_out, serial_bus_unit_disable, disk_unit_disable, low_io_bus_select;
  logic cpu_hard_restart_pin, cpu_warm_init, eisa_port_hit, extra_clock_port_hit;
  logic isa_master_grant, isa_fwd_to_pci;
  logic [3:0] disk_primary_irq_sel, disk_secondary_irq_sel, pci_int_out, pci_int_edge;
  int miscompares = 0;
  int n_compared = 0;
  // index 5 is an unmapped offset; the command byte is skipped in the all-ones pass
  localparam logic [7:0] OFS [13] = '{8'h04, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A,
    8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h54};
  localparam logic [7:0] RSTV [13] = '{8'h0B, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h04,
    8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h00};
  localparam logic [7:0] ONESV [13] = '{8'h0B, 8'hFF, 8'h13, 8'hF7, 8'h0F, 8'h00, 8'hCF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h04, 8'h0F};
  localparam logic [3:0] IRQN [4] = '{4'hE, 4'hF, 4'hA, 4'hB};

  pibr_config_regs i_pibr_config_regs (.sys_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .dma_chan0_fast_timing, .dma_chan1_fast_timing,
    .dma_chan2_fast_timing, .dma_chan3_fast_timing, .dma_chan5_fast_timing,
    .dma_chan6_fast_timing, .dma_chan7_fast_timing, .line_buffer_enable, .io_space_enable,
    .mem_space_enable, .special_cycle_enable, .burst_read_no_break, .posted_write_enable,
    .delayed_txn_enable, .irq_ctrl_shadow_enable, .write_delay_timer_enable,
    .read_delay_timer_enable, .bus_reset_out, .serial_bus_unit_disable, .disk_unit_disable,
    .low_io_bus_select, .restart_req, .cpu_hard_restart_pin, .cpu_warm_init, .io_addr,
    .io_access, .eisa_port_hit, .extra_clock_port_hit, .isa_master_req, .bridge_bus_grant,
    .isa_master_grant, .isa_addr, .isa_fwd_to_pci, .disk_primary_irq_sel,
    .disk_secondary_irq_sel, .pci_int_line_a, .pci_int_line_b, .pci_int_line_c,
    .pci_int_line_d, .pci_int_out, .pci_int_edge);

  pibr_arbiter_model i_pibr_arbiter_model (.sys_clk, .rst_n, .bus_req(isa_master_req),
    .grant_delay, .bridge_bus_grant);

  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // every drive lands 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // the extra idle cycle lets the registered outputs settle before anyone looks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr = a;
    cfg_rd = 1'b1;
    step(1);
    cfg_rd = 1'b0;
    chk(cfg_rdata, exp);
    step(1);
  endtask

  task automatic fchk(input logic [23:0] a, input logic exp);
    isa_addr = a;
    step(2);
    chk(8'(isa_fwd_to_pci), 8'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 13; i++) rchk(OFS[i], RSTV[i]);
    chk({line_buffer_enable, dma_chan7_fast_timing, dma_chan6_fast_timing,
      dma_chan5_fast_timing, dma_chan3_fast_timing, dma_chan2_fast_timing,
      dma_chan1_fast_timing, dma_chan0_fast_timing}, 8'h00);
    chk({1'b0, burst_read_no_break, posted_write_enable, delayed_txn_enable,
      irq_ctrl_shadow_enable, write_delay_timer_enable, read_delay_timer_enable,
      bus_reset_out}, 8'h00);
    chk({disk_secondary_irq_sel, disk_primary_irq_sel}, 8'hFE);
    for (int i = 1; i < 13; i++) wr(OFS[i], 8'hFF);
    for (int i = 1; i < 13; i++) rchk(OFS[i], ONESV[i]);
    chk({line_buffer_enable, dma_chan7_fast_timing, dma_chan6_fast_timing,
      dma_chan5_fast_timing, dma_chan3_fast_timing, dma_chan2_fast_timing,
      dma_chan1_fast_timing, dma_chan0_fast_timing}, 8'hFF);
    chk({1'b0, burst_read_no_break, posted_write_enable, delayed_txn_enable,
      irq_ctrl_shadow_enable, write_delay_timer_enable, read_delay_timer_enable,
      bus_reset_out}, 8'h7F);
    chk({5'h00, serial_bus_unit_disable, disk_unit_disable, low_io_bus_select},
      8'h07);
    chk(8'(pci_int_edge), 8'h0F);
    for (int i = 1; i < 13; i++) wr(OFS[i], RSTV[i]);
    chk(8'(bus_reset_out), 8'h00);
  endtask

  task automatic t_cmd_mode();
    wr(8'h04, 8'h00);
    rchk(8'h04, 8'h03);
    wr(8'h46, 8'h10);
    wr(8'h04, 8'h00);
    rchk(8'h04, 8'h08);
    chk({6'h00, io_space_enable, mem_space_enable}, 8'h00);
    wr(8'h04, 8'h0F);
    // bit 3 is read-only in test mode, so special cycles stay off from the first write
    chk({5'h00, special_cycle_enable, mem_space_enable, io_space_enable}, 8'h03);
    wr(8'h46, 8'h00);
    rchk(8'h04, 8'h03);
    wr(8'h04, 8'h08);
    rchk(8'h04, 8'h0B);
  endtask

  task automatic t_forwarding();
    fchk(24'h000000, 1'b1);
    fchk(24'h0A0000, 1'b0);
    fchk(24'h17FFFF, 1'b1);
    fchk(24'h180000, 1'b0);
    wr(8'h4E, 8'h01);
    fchk(24'h0C3FFF, 1'b1);
    wr(8'h4C, 8'h10);
    wr(8'h4D, 8'h11);
    fchk(24'h100000, 1'b0);
    fchk(24'h110000, 1'b1);
    wr(8'h4C, 8'h11);
    wr(8'h4D, 8'h10);
    fchk(24'h100000, 1'b1);
    wr(8'h48, 8'h00);
    fchk(24'h100000, 1'b0);
    wr(8'h4F, 8'h13);
    fchk(24'h1FFFFF, 1'b1);
    fchk(24'h200000, 1'b0);
    for (int i = 7; i < 11; i++) wr(OFS[i], RSTV[i]);
    wr(8'h48, 8'h01);
  endtask

  task automatic t_routing();
    for (int c = 0; c < 4; c++) begin
      wr(8'h4A, 8'(c * 5));
      chk({disk_secondary_irq_sel, disk_primary_irq_sel}, {2{IRQN[c]}});
    end
    wr(8'h4A, 8'h04);
    pci_int_line_a = 1'b1;
    pci_int_line_c = 1'b1;
    step(8);
    chk(8'(pci_int_out), 8'h0A);
    wr(8'h54, 8'h0C);
    chk(8'({pci_int_edge, pci_int_out}), 8'hC6);
    wr(8'h54, 8'h00);
  endtask

  task automatic t_misc();
    restart_req = 1'b1;
    io_access = 1'b1;
    io_addr = 16'h04D1;
    wr(8'h47, 8'h21);
    chk({5'h00, bus_reset_out, cpu_hard_restart_pin, cpu_warm_init}, 8'h06);
    chk({6'h00, eisa_port_hit, extra_clock_port_hit}, 8'h02);
    wr(8'h47, 8'h80);
    chk({5'h00, eisa_port_hit, cpu_hard_restart_pin, cpu_warm_init}, 8'h01);
    io_addr = 16'h0075;
    step(2);
    chk({6'h00, eisa_port_hit, extra_clock_port_hit}, 8'h01);
    wr(8'h48, 8'h09);
    chk(8'(extra_clock_port_hit), 8'h00);
    wr(8'h48, 8'h01);
    wr(8'h47, 8'h00);
    restart_req = 1'b0;
    io_access = 1'b0;
  endtask

  task automatic t_grant();
    int n;
    wr(8'h4A, 8'h84);
    isa_master_req = 1'b1;
    step(2);
    chk(8'(isa_master_grant), 8'h00);
    n = 0;
    while (isa_master_grant !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    if (n == 30) begin
      miscompares++;
      complete_run();
    end
    chk(8'(bridge_bus_grant), 8'h01);
    isa_master_req = 1'b0;
    grant_delay = 5'h14;
    wr(8'h4A, 8'h04);
    isa_master_req = 1'b1;
    step(2);
    chk({6'h00, isa_master_grant, bridge_bus_grant}, 8'h02);
    isa_master_req = 1'b0;
    step(2);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_cmd_mode();
    t_forwarding();
    t_routing();
    t_misc();
    t_grant();
    complete_run();
  end
endmodule
